// ==== rtl/timer_capture_reload_pwm.sv ====
// Purpose: 16-bit timer/counter with prescaler, capture, reload and PWM.
// Assumes: Pin inputs are synchronised here; pins share output/enable/input.
// Notes: Output enables are active low; software writes win over hardware updates, except ovf and ext, where hardware events apply on top of a write.
//
// Decided for this implementation: the register offsets and the plain strobed port.
`include "timer_defines.svh"

module timer_capture_reload_pwm
	import timer_pkg::*;
#(
	parameter int PRESC_W = 10
) (
	input wire logic clk,
	input wire logic nrst,
	input wire bus_req_s regReq,
	output logic [15:0] regRdata,
	output logic irqReq,
	input wire logic clkPinIn,
	output logic clkPinOut,
	output logic clkPinOe_n,
	input wire logic capPinIn,
	output logic capPinOut,
	output logic capPinOe_n
);

	if (PRESC_W < `PS_MIN_W) begin : g_bad_width
		$error("PRESC_W too narrow for divide by 1024");
	end

	////////////////////////////////////////////////////////////////////////
	// Registers and pin synchronisers

	logic [15:0] ctrl_q, ctrl_d;
	logic [15:0] cnt_q, cnt_d;
	logic [15:0] rld_q, rld_d;
	logic [15:0] cmp_q;
	logic [PRESC_W-1:0] ps_q, ps_d;
	logic dirDown_q, dirDown_d;
	logic extIrq_q, extIrq_d;
	logic pwmOut_q, pwmOut_d;
	logic sqOut_q;
	logic [2:0] capSync_q;
	logic [2:0] clkSync_q;
	logic [15:0] rdata_q;
	logic irq_q;
	logic clkOe_n_q;
	logic capOe_n_q;

	ctrl_s ctl;
	assign ctl = ctrl_s'(ctrl_q);

	// Stage 0 feeds stage 1 only; edges are seen between stages 1 and 2
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			capSync_q <= 3'h0;
			clkSync_q <= 3'h0;
		end else begin
			capSync_q <= {capSync_q[1:0], capPinIn};
			clkSync_q <= {clkSync_q[1:0], clkPinIn};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Decode

	wire wrCtrl = regReq.write && regReq.addr == `ADDR_CTRL;
	wire wrCount = regReq.write && regReq.addr == `ADDR_COUNT;
	wire wrReload = regReq.write && regReq.addr == `ADDR_RELOAD;
	wire wrCompare = regReq.write && regReq.addr == `ADDR_COMPARE;

	wire capLevel = capSync_q[1];
	wire capFall = capSync_q[2] && !capSync_q[1];
	wire clkEdge = clkSync_q[2] ^ clkSync_q[1];
	wire pwm = ctl.pwmClr || ctl.pwmSet;

	// Halted timer keeps every piece of state except the prescaler, which is cleared, and the pin synchronisers, which keep sampling
	wire active = ctl.run;

	logic [9:0] psTerm;
	always_comb begin
		unique case (ctl.presc)
			3'h1: psTerm = `PS_TERM_4;
			3'h2: psTerm = `PS_TERM_16;
			3'h3: psTerm = `PS_TERM_64;
			3'h4: psTerm = `PS_TERM_256;
			3'h5: psTerm = `PS_TERM_1024;
			default: psTerm = `PS_TERM_1;
		endcase
	end

	wire psDone = ps_q == PRESC_W'(psTerm);
	wire tick = active && (ctl.cntSel ? clkEdge : psDone);

	// Pin level steers direction only outside PWM
	wire down = ctl.dirEn && (pwm ? dirDown_q : !capLevel);

	wire edgeEv = active && ctl.extEn && capFall;
	wire capEv = active && ctl.capSel && capFall;
	wire extReload = edgeEv && !ctl.capSel;
	wire extSet = edgeEv && (ctl.capSel || !down || pwm);

	////////////////////////////////////////////////////////////////////////
	// Count path

	logic ovfEv;
	always_comb begin
		cnt_d = cnt_q;
		dirDown_d = dirDown_q;
		ovfEv = 1'b0;
		if (extReload) begin
			cnt_d = down ? rld_q : `WORD_ZERO;
		end else if (tick) begin
			if (!ctl.capSel && pwm && ctl.dirEn) begin
				if (!dirDown_q && cnt_q == rld_q) begin
					dirDown_d = 1'b1;
					cnt_d = cnt_q - `WORD_ONE;
					ovfEv = 1'b1;
				end else if (dirDown_q && cnt_q == `WORD_ZERO) begin
					dirDown_d = 1'b0;
					cnt_d = cnt_q + `WORD_ONE;
					ovfEv = 1'b1;
				end else begin
					cnt_d = dirDown_q ? cnt_q - `WORD_ONE : cnt_q + `WORD_ONE;
				end
			end else if (!ctl.capSel && !down && cnt_q == rld_q) begin
				cnt_d = `WORD_ZERO;
				ovfEv = 1'b1;
			end else if (!ctl.capSel && down && cnt_q == `WORD_ZERO) begin
				cnt_d = rld_q;
				ovfEv = 1'b1;
			end else begin
				cnt_d = down ? cnt_q - `WORD_ONE : cnt_q + `WORD_ONE;
				ovfEv = down ? cnt_q == `WORD_ZERO : cnt_q == `WORD_MAX;
			end
		end
		if (wrCount) begin
			cnt_d = regReq.wdata;
		end
	end

	assign ps_d = (!active || ctl.cntSel || psDone) ? PRESC_W'(`PS_ZERO) : ps_q + PRESC_W'(`PS_STEP);
	assign rld_d = wrReload ? regReq.wdata : capEv ? cnt_q : rld_q;

	////////////////////////////////////////////////////////////////////////
	// Flags, interrupt and PWM

	wire extToggle = ovfEv && !ctl.capSel && !pwm;

	ctrl_s cw;
	always_comb begin
		cw = ctrl_s'(wrCtrl ? (regReq.wdata & `CTRL_WMASK) : ctrl_q);
		cw.rsv = 2'h0;
		if (extSet) begin
			cw.ext = 1'b1;
		end else if (extToggle) begin
			cw.ext = !cw.ext;
		end
		cw.ovf = cw.ovf || ovfEv;
		ctrl_d = 16'(cw);
	end

	// Toggles do not raise requests, so edge events are tracked apart
	assign extIrq_d = extSet || (extIrq_q && !(wrCtrl && !regReq.wdata[6]));

	wire cmpHit = tick && cnt_d == cmp_q;
	wire rldHit = tick && cnt_d == rld_q;
	always_comb begin
		pwmOut_d = pwmOut_q;
		if (ctl.pwmClr && ctl.pwmSet) begin
			if (cmpHit) begin
				pwmOut_d = !pwmOut_q;
			end
		end else if (ctl.pwmClr) begin
			if (cmpHit) begin
				pwmOut_d = 1'b0;
			end else if (rldHit) begin
				pwmOut_d = 1'b1;
			end
		end else if (ctl.pwmSet) begin
			if (cmpHit) begin
				pwmOut_d = 1'b1;
			end else if (rldHit) begin
				pwmOut_d = 1'b0;
			end
		end
	end

	logic [15:0] rdMux;
	assign rdMux = regReq.addr == `ADDR_CTRL ? ctrl_q :
		regReq.addr == `ADDR_COUNT ? cnt_q :
		regReq.addr == `ADDR_RELOAD ? rld_q : cmp_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_q <= `CTRL_RESET;
			cnt_q <= `WORD_ZERO;
			rld_q <= `WORD_ZERO;
			cmp_q <= `WORD_ZERO;
			ps_q <= '0;
			dirDown_q <= 1'b0;
			extIrq_q <= 1'b0;
			pwmOut_q <= 1'b0;
			sqOut_q <= 1'b0;
			rdata_q <= `WORD_ZERO;
			irq_q <= 1'b0;
			clkOe_n_q <= 1'b1;
			capOe_n_q <= 1'b1;
		end else begin
			ctrl_q <= ctrl_d;
			cnt_q <= cnt_d;
			rld_q <= rld_d;
			cmp_q <= wrCompare ? regReq.wdata : cmp_q;
			ps_q <= ps_d;
			dirDown_q <= dirDown_d;
			extIrq_q <= extIrq_d;
			pwmOut_q <= pwmOut_d;
			sqOut_q <= sqOut_q ^ ovfEv;
			rdata_q <= regReq.read ? rdMux : `WORD_ZERO;
			irq_q <= ctl.irqEn && (ctl.ovf || extIrq_q);
			clkOe_n_q <= !(ctl.outEn && !ctl.cntSel);
			capOe_n_q <= !pwm;
		end
	end

	assign regRdata = rdata_q;
	assign irqReq = irq_q;
	assign clkPinOut = sqOut_q;
	assign clkPinOe_n = clkOe_n_q;
	assign capPinOut = pwmOut_q;
	assign capPinOe_n = capOe_n_q;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	property p_reload_up;
		tick && !extReload && !wrCount && !ctl.capSel && !pwm && !down && cnt_q == rld_q
			|=> cnt_q == `WORD_ZERO && ctl.ovf;
	endproperty
	a_reload_up: assert property (p_reload_up) else $error("Up count missed reload to zero");

	property p_reload_down;
		tick && !extReload && !wrCount && !ctl.capSel && !pwm && down && cnt_q == `WORD_ZERO
			|=> cnt_q == $past(rld_q);
	endproperty
	a_reload_down: assert property (p_reload_down) else $error("Down count missed reload");

	property p_capture;
		capEv && !wrReload |=> rld_q == $past(cnt_q);
	endproperty
	a_capture: assert property (p_capture) else $error("Capture did not latch count");

	property p_irq_gate;
		!ctl.irqEn |=> !irqReq;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("Interrupt while disabled");

	property p_halt;
		!ctl.run && !regReq.write |=> $stable(cnt_q) && $stable(pwmOut_q) && $stable(ctrl_q);
	endproperty
	a_halt: assert property (p_halt) else $error("State moved while halted");

	property p_ovf_sticky;
		ctl.ovf && !wrCtrl |=> ctl.ovf;
	endproperty
	a_ovf_sticky: assert property (p_ovf_sticky) else $error("Overflow flag cleared by hardware");

	property p_presc;
		tick && !ctl.cntSel |-> ps_q == PRESC_W'(psTerm);
	endproperty
	a_presc: assert property (p_presc) else $error("Tick off prescaler terminal");

	property p_pwm_clr;
		ctl.pwmClr && !ctl.pwmSet && cmpHit |=> !capPinOut;
	endproperty
	a_pwm_clr: assert property (p_pwm_clr) else $error("PWM clear did not drive low");

	property p_ext_toggle;
		extToggle && !extSet && !wrCtrl |=> ctl.ext != $past(ctl.ext) && extIrq_q == $past(extIrq_q);
	endproperty
	a_ext_toggle: assert property (p_ext_toggle) else $error("Flag toggle wrong");

	property p_rsv;
		$past(regReq.read) && $past(regReq.addr) == `ADDR_CTRL |-> regRdata[14:13] == 2'h0;
	endproperty
	a_rsv: assert property (p_rsv) else $error("Reserved bits read non-zero");

	property p_ext_reload;
		extReload && !wrCount |=> cnt_q == ($past(down) ? $past(rld_q) : `WORD_ZERO);
	endproperty
	a_ext_reload: assert property (p_ext_reload) else $error("Edge reload wrong");

	property p_dir_up;
		tick && !ctl.dirEn && !extReload && !wrCount && cnt_q != rld_q |=> cnt_q == $past(cnt_q) + `WORD_ONE;
	endproperty
	a_dir_up: assert property (p_dir_up) else $error("Count did not step up");

	property p_pwm_turn;
		tick && !extReload && !wrCount && !ctl.capSel && pwm && ctl.dirEn && !dirDown_q && cnt_q == rld_q
			|=> dirDown_q;
	endproperty
	a_pwm_turn: assert property (p_pwm_turn) else $error("PWM did not turn at reload");

	property p_out_drive;
		ctl.outEn && !ctl.cntSel |=> !clkPinOe_n;
	endproperty
	a_out_drive: assert property (p_out_drive) else $error("Clock pin not driven");

	property p_ext_flag;
		extSet |=> ctl.ext && extIrq_q;
	endproperty
	a_ext_flag: assert property (p_ext_flag) else $error("Edge flag not set");

	property p_ext_quiet;
		extToggle && !extSet && !extIrq_q |=> !extIrq_q;
	endproperty
	a_ext_quiet: assert property (p_ext_quiet) else $error("Toggle raised a request");

	property p_ovf_set;
		ovfEv |=> ctl.ovf;
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("Overflow flag not set");

	property p_irq_raise;
		ctl.irqEn && ctl.ovf |=> irqReq;
	endproperty
	a_irq_raise: assert property (p_irq_raise) else $error("Enabled flag gave no request");

	property p_counter;
		ctl.cntSel && clkSync_q[2] == clkSync_q[1] |-> !tick;
	endproperty
	a_counter: assert property (p_counter) else $error("Counter ticked without pin edge");

	property p_pwm_clr_rld;
		ctl.pwmClr && !ctl.pwmSet && rldHit && !cmpHit |=> capPinOut;
	endproperty
	a_pwm_clr_rld: assert property (p_pwm_clr_rld) else $error("PWM clear missed reload high");

	property p_pwm_set;
		ctl.pwmSet && !ctl.pwmClr && cmpHit |=> capPinOut;
	endproperty
	a_pwm_set: assert property (p_pwm_set) else $error("PWM set did not drive high");

	property p_pwm_toggle;
		ctl.pwmClr && ctl.pwmSet && cmpHit |=> capPinOut != $past(capPinOut);
	endproperty
	a_pwm_toggle: assert property (p_pwm_toggle) else $error("PWM did not toggle");

	c_ovf: cover property (ovfEv ##1 ctl.ovf);
	c_capture: cover property (capEv);
	c_pwm_toggle: cover property (ctl.pwmClr && ctl.pwmSet && cmpHit);
	c_updown: cover property (dirDown_q ##[1:1000] !dirDown_q);
	c_ext_reload: cover property (extReload);

endmodule : timer_capture_reload_pwm

// ==== rtl/timer_defines.svh ====
// Purpose: Register map, control write mask and counts for the 16-bit timer.
// Assumes: Word-wide registers on a two-bit register index.
// Notes: Definitions only.
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

`define ADDR_CTRL 2'h0
`define ADDR_COUNT 2'h1
`define ADDR_RELOAD 2'h2
`define ADDR_COMPARE 2'h3

`define CTRL_WMASK 16'h9FFF
`define CTRL_RESET 16'h0000
`define WORD_ZERO 16'h0000
`define WORD_ONE 16'h0001
`define WORD_MAX 16'hFFFF

`define PS_TERM_1 10'h000
`define PS_TERM_4 10'h003
`define PS_TERM_16 10'h00F
`define PS_TERM_64 10'h03F
`define PS_TERM_256 10'h0FF
`define PS_TERM_1024 10'h3FF
`define PS_ZERO 10'h000
`define PS_STEP 10'h001
`define PS_MIN_W 10

`endif

// ==== rtl/timer_pkg.sv ====
// Purpose: Types shared by the timer and its bench.
// Assumes: Field layout of the control/status word, bit 15 down to bit 0.
// Notes: Reserved field always held at zero.
package timer_pkg;

	typedef struct packed {
		logic cntSel;
		logic [1:0] rsv;
		logic pwmSet;
		logic pwmClr;
		logic [2:0] presc;
		logic ovf;
		logic ext;
		logic outEn;
		logic dirEn;
		logic extEn;
		logic run;
		logic irqEn;
		logic capSel;
	} ctrl_s;

	typedef struct packed {
		logic [1:0] addr;
		logic [15:0] wdata;
		logic write;
		logic read;
	} bus_req_s;

endpackage : timer_pkg

// ==== sim/pin_model.sv ====
// Purpose: Far-side pins of the timer: capture/direction and clock/output lines.
// Assumes: A pin is driven by the timer whenever its active-low enable is low.
// Notes: Bench sets the levels the outside world puts on released pins.
module pin_model (
	input wire logic capPinOut,
	input wire logic capPinOe_n,
	input wire logic clkPinOut,
	input wire logic clkPinOe_n,
	input wire logic capDrive,
	input wire logic clkDrive,
	output logic capWire,
	output logic clkWire
);
	// Outside level only while the timer lets go, never a fight
	assign capWire = capPinOe_n ? capDrive : capPinOut;
	assign clkWire = clkPinOe_n ? clkDrive : clkPinOut;
endmodule : pin_model

// ==== sim/tb_top.sv ====
// Purpose: Self-checking bench for the 16-bit timer.
// Assumes: Register bus with read data one cycle after the strobe.
// Notes: Counts are checked exactly from the strobe-to-tick timing.
`include "timer_defines.svh"
module tb_top
	import timer_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, nrst, capDrive, clkDrive, capWire, clkWire;
	logic clkPinOut, clkPinOe_n, capPinOut, capPinOe_n, irqReq;
	logic [15:0] regRdata, v, w;
	bus_req_s regReq;
	int error_cnt = 0;
	int samples_checked = 0;
	int lows;
	int divs[8] = '{1, 4, 16, 64, 256, 1024, 1, 1};
	logic [15:0] pwmModes[4] = '{16'h0804, 16'h1004, 16'h1804, 16'h0814};
	int pwmLows[4] = '{600, 240, 420, 525};
	timer_capture_reload_pwm dut_u (.clk(clk), .nrst(nrst), .regReq(regReq), .regRdata(regRdata),
		.irqReq(irqReq), .clkPinIn(clkWire), .clkPinOut(clkPinOut), .clkPinOe_n(clkPinOe_n),
		.capPinIn(capWire), .capPinOut(capPinOut), .capPinOe_n(capPinOe_n));
	pin_model pins_u (.capPinOut(capPinOut), .capPinOe_n(capPinOe_n), .clkPinOut(clkPinOut),
		.clkPinOe_n(clkPinOe_n), .capDrive(capDrive), .clkDrive(clkDrive), .capWire(capWire),
		.clkWire(clkWire));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task report_and_stop;
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop
	task chk(input bit ok, input string msg);
		samples_checked++;
		if (!ok) begin
			error_cnt++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask : chk
	// Gap cycle before each strobe keeps one assignment per time step
	task wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge clk);
		regReq <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
		@(posedge clk);
		regReq <= '0;
	endtask : wr
	task rd(input logic [1:0] a, output logic [15:0] d);
		@(posedge clk);
		regReq <= '{addr: a, wdata: 16'h0000, write: 1'b0, read: 1'b1};
		@(posedge clk);
		regReq <= '0;
		#1 d = regRdata;
	endtask : rd
	////////////////////////////////////////////////////////////////////////////////
	task t_regs;
		wr(`ADDR_CTRL, 16'h6000);
		rd(`ADDR_CTRL, v);
		chk(v === 16'h0000, "reserved bits");
		wr(`ADDR_COMPARE, 16'hA5C3);
		rd(`ADDR_COMPARE, v);
		chk(v === 16'hA5C3, "compare readback");
	endtask : t_regs
	task t_presc;
		for (int i = 0; i < 8; i++) begin
			wr(`ADDR_RELOAD, 16'hFFFF);
			wr(`ADDR_COUNT, 16'h0000);
			wr(`ADDR_CTRL, 16'(i << 8) | 16'h0004);
			repeat (4094) @(posedge clk);
			wr(`ADDR_CTRL, 16'h0000);
			rd(`ADDR_COUNT, v);
			chk(v === 16'(4096 / divs[i]), "prescale");
		end
	endtask : t_presc
	task t_reload(input logic lvl);
		capDrive <= lvl;
		wr(`ADDR_RELOAD, 16'h000A);
		wr(`ADDR_COUNT, 16'h0003);
		wr(`ADDR_CTRL, 16'h0014);
		repeat (41) @(posedge clk);
		rd(`ADDR_CTRL, v);
		chk(v[7] === 1'b1, "overflow set");
		wr(`ADDR_CTRL, 16'h0090);
		rd(`ADDR_COUNT, v);
		chk(v === (lvl ? 16'h0004 : 16'h0002), "reload wrap");
		repeat (20) @(posedge clk);
		rd(`ADDR_COUNT, w);
		chk(v === w, "halt holds");
		rd(`ADDR_CTRL, v);
		chk(v[7] === 1'b1, "overflow flag");
		wr(`ADDR_CTRL, 16'h0000);
		rd(`ADDR_CTRL, v);
		chk(v[7] === 1'b0, "flag cleared");
	endtask : t_reload
	task t_capture;
		capDrive <= 1'b1;
		wr(`ADDR_COUNT, 16'h0000);
		wr(`ADDR_RELOAD, 16'h0000);
		wr(`ADDR_CTRL, 16'h000F);
		repeat (20) @(posedge clk);
		capDrive <= 1'b0;
		repeat (8) @(posedge clk);
		rd(`ADDR_RELOAD, v);
		rd(`ADDR_COUNT, w);
		chk(v === 16'h0016 && v < w, "capture");
		rd(`ADDR_CTRL, v);
		chk(v[6] === 1'b1 && irqReq === 1'b1, "edge flag irq");
		wr(`ADDR_CTRL, 16'h004D);
		repeat (3) @(posedge clk);
		chk(irqReq === 1'b0, "irq gated");
		wr(`ADDR_CTRL, 16'h0000);
	endtask : t_capture
	task t_pwm;
		for (int m = 0; m < 4; m++) begin
			wr(`ADDR_RELOAD, 16'd20);
			wr(`ADDR_COMPARE, 16'd5);
			wr(`ADDR_COUNT, 16'h0000);
			wr(`ADDR_CTRL, pwmModes[m]);
			repeat (50) @(posedge clk);
			lows = 0;
			repeat (840) begin
				@(posedge clk);
				#1 lows += (capPinOut === 1'b0);
			end
			chk(capPinOe_n === 1'b0 && lows == pwmLows[m], "pwm duty");
			wr(`ADDR_CTRL, 16'h0000);
		end
	endtask : t_pwm
	task t_pins;
		logic prev;
		int flips;
		wr(`ADDR_RELOAD, 16'h0004);
		wr(`ADDR_COUNT, 16'h0000);
		wr(`ADDR_CTRL, 16'h0024);
		repeat (20) @(posedge clk);
		#1 prev = clkPinOut;
		chk(clkPinOe_n === 1'b0, "output drive");
		flips = 0;
		repeat (50) begin
			@(posedge clk);
			#1 flips += (clkPinOut !== prev);
			prev = clkPinOut;
		end
		chk(flips == 10, "square wave");
		wr(`ADDR_CTRL, 16'h8020);
		repeat (6) @(posedge clk);
		chk(clkPinOe_n === 1'b1, "counter releases pin");
		wr(`ADDR_RELOAD, 16'hFFFF);
		wr(`ADDR_COUNT, 16'h0000);
		wr(`ADDR_CTRL, 16'h8024);
		repeat (10) begin
			repeat (8) @(posedge clk);
			clkDrive <= ~clkDrive;
		end
		repeat (8) @(posedge clk);
		rd(`ADDR_COUNT, v);
		chk(v === 16'd10, "pin transitions");
	endtask : t_pins
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		nrst = 1'b0;
		regReq = '0;
		capDrive = 1'b1;
		clkDrive = 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		t_regs();
		t_presc();
		t_reload(1'b1);
		t_reload(1'b0);
		t_capture();
		t_pwm();
		t_pins();
		report_and_stop();
	end
	// Hang guard
	initial begin
		repeat (100000) @(posedge clk);
		error_cnt++;
		report_and_stop();
	end
endmodule : tb_top
